/* File: hdl/dfc_pkg.sv */
// constants and types shared by the drive frequency conditioning block
package dfc_pkg;
  // register byte offsets on the AHB-Lite slave
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_FDET    = 8'h04;
  localparam logic [7:0] ADDR_OUTSEL  = 8'h08;
  localparam logic [7:0] ADDR_OFSMODE = 8'h0C;
  localparam logic [7:0] ADDR_FREQ1   = 8'h10;
  localparam logic [7:0] ADDR_FREQ2   = 8'h14;
  localparam logic [7:0] ADDR_FREQ3   = 8'h18;
  localparam logic [7:0] ADDR_JWIDTH  = 8'h1C;
  localparam logic [7:0] ADDR_MISEL   = 8'h20;
  localparam logic [7:0] ADDR_STATUS  = 8'h24;
  localparam logic [7:0] ADDR_FCMD    = 8'h28;

  // control register fields
  localparam int CTRL_VEC_BIT   = 0;
  localparam int CTRL_SRC_BIT   = 1;
  localparam int CTRL_LIMIT_LSB = 8;
  // status register fields
  localparam int STAT_ERR_BIT   = 3;
  localparam int STAT_LATCH_BIT = 4;
  localparam int STAT_CUR_BIT   = 5;
  localparam int STAT_CNT_LSB   = 8;
  // offset mode fields: upper digit in [7:4], lower digit in [3:0]
  localparam int OFS_X_LSB      = 4;

  // reset values
  localparam logic [15:0] RST_FREQ     = 16'h0000;
  localparam logic [7:0]  RST_OFS_MODE = 8'h00;
  localparam logic [7:0]  RST_CODE     = 8'h00;

  // selector codes
  localparam logic [7:0] FN_FREQ_GE = 8'h04;
  localparam logic [7:0] FN_FREQ_LE = 8'h05;
  localparam logic [7:0] MI_OFS1    = 8'h1E;
  localparam logic [7:0] MI_OFS2    = 8'h1F;
  localparam logic [7:0] MI_OFS3    = 8'h21;
  localparam logic [3:0] MODE_JUMP  = 4'h0;
  localparam logic [3:0] MODE_HZ    = 4'h1;
  localparam logic [3:0] MODE_PCT   = 4'h2;

  // ranges, 0.01 Hz and 0.01 % steps
  localparam logic [15:0] FREQ_LIMIT = 16'h9C40;
  localparam logic [31:0] PCT_FULL   = 32'h0000_2710;
  localparam logic [3:0]  RETRY_MAX  = 4'hA;

  // timing at 20 MHz
  localparam longint unsigned CLK_HZ           = 64'd20_000_000;
  localparam longint unsigned ERR_HOLD_MS      = 64'd1000;
  localparam longint unsigned ERR_HOLD_CYCLES  = CLK_HZ / 64'd1000 * ERR_HOLD_MS;
  localparam longint unsigned RETRY_WINDOW_MIN = 64'd10;
  localparam longint unsigned RETRY_WINDOW_CYCLES = CLK_HZ * 64'd60 * RETRY_WINDOW_MIN;

  typedef enum logic [1:0] {
    RT_IDLE  = 2'b00,
    RT_WATCH = 2'b01,
    RT_LATCH = 2'b10
  } dfc_retry_state_t;
endpackage

/* File: hdl/dfc_retry.sv */
// automatic fault retry counter and fault latch
`timescale 1ns/1ps
module dfc_retry #(
  parameter longint unsigned WINDOW_CYCLES = dfc_pkg::RETRY_WINDOW_CYCLES
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       ce_in,
  input  wire logic       fault_oc_in,
  input  wire logic       fault_ov_in,
  input  wire logic       fault_other_in,
  input  wire logic       fault_reset_in,
  input  wire logic [3:0] limit_in,
  output logic      [3:0] count_out,
  output logic            latched_out,
  output logic            restart_out
);
  dfc_pkg::dfc_retry_state_t state;
  logic [33:0] timer;
  logic        oc_q;
  logic        ov_q;
  logic        other_q;

  // rising edges of the fault levels
  wire retry_rise = (fault_oc_in & ~oc_q) | (fault_ov_in & ~ov_q);
  wire other_rise = fault_other_in & ~other_q;
  wire may_retry  = count_out < limit_in;
  // a fault arriving with the reset is kept, so the event is never lost
  wire clear_now  = fault_reset_in && !retry_rise && !other_rise;
  wire window_end = timer == 34'(WINDOW_CYCLES - 64'd1);

  assign latched_out = state == dfc_pkg::RT_LATCH;

  // retry sequencer; reset input clears state, count and timer unless a fault edge comes with it, power loss is rst_in
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state       <= dfc_pkg::RT_IDLE;
      count_out   <= 4'h0;
      timer       <= 34'h0;
      restart_out <= 1'b0;
      oc_q        <= 1'b0;
      ov_q        <= 1'b0;
      other_q     <= 1'b0;
    end else if (ce_in) begin
      oc_q        <= fault_oc_in;
      ov_q        <= fault_ov_in;
      other_q     <= fault_other_in;
      restart_out <= 1'b0;
      if (clear_now) begin
        state     <= dfc_pkg::RT_IDLE;
        count_out <= 4'h0;
        timer     <= 34'h0;
      end else begin
        unique case (state)
          dfc_pkg::RT_IDLE, dfc_pkg::RT_WATCH: begin
            if (other_rise) begin
              state <= dfc_pkg::RT_LATCH;
            end else if (retry_rise && may_retry) begin
              count_out   <= count_out + 4'h1;
              restart_out <= 1'b1;
              state       <= dfc_pkg::RT_WATCH;
              timer       <= 34'h0;
            end else if (retry_rise) begin
              state <= dfc_pkg::RT_LATCH;
            end else if (state == dfc_pkg::RT_WATCH) begin
              if (window_end) begin
                count_out <= 4'h0;
                state     <= dfc_pkg::RT_IDLE;
              end else begin
                timer <= timer + 34'h1;
              end
            end
          end
          dfc_pkg::RT_LATCH: begin
            state <= dfc_pkg::RT_LATCH;
          end
          default: begin
            state <= dfc_pkg::RT_IDLE;
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  AST_RETRY_RESTART: assert property (
    ce_in && !fault_reset_in && retry_rise && !other_rise && may_retry && !latched_out
    |=> restart_out && count_out == $past(count_out) + 4'h1)
    else $error("retry did not restart and count");
  AST_OTHER_LATCH: assert property (
    ce_in && other_rise |=> latched_out && !restart_out)
    else $error("non-retryable fault not latched");
  AST_RESET_CLEAR: assert property (
    ce_in && clear_now |=> count_out == 4'h0 && !latched_out)
    else $error("fault reset did not clear counter");
endmodule

/* File: hdl/dfc_top.sv */
// drive frequency conditioning: register file, detection, jump bands, offsets
// Contract
// - vector mode: source 0 torque, 1 current
// - V/f mode always detects by current
// - output code 4: on when freq >= level
// - output code 5: on when freq <= level
// - zero prohibited frequency disables that band
// - misordered jump frequencies: error one second, restore
// - avoid bands when steady, pass while ramping
// - retry restarts while count below limit (<=10)
// - only overcurrent and overvoltage faults retry
// - ten fault-free minutes clear retry count
// - fault reset or power loss clears count; a fault reset cycle that meets a new fault edge does not clear it
// - entries 0.01 Hz to 400 Hz, or 0.01 %
// - lower mode digit sets each offset sign
// - add selected signed offsets to reference
// - input codes 30, 31, 33 select offsets
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
module dfc_top #(
  parameter longint unsigned ERR_HOLD_CYCLES     = dfc_pkg::ERR_HOLD_CYCLES,
  parameter longint unsigned RETRY_WINDOW_CYCLES = dfc_pkg::RETRY_WINDOW_CYCLES
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic [15:0] freq_ref_in,
  input  wire logic [15:0] out_freq_in,
  input  wire logic [15:0] max_freq_in,
  input  wire logic        ramping_in,
  input  wire logic [3:0]  multi_in,
  input  wire logic        fault_oc_in,
  input  wire logic        fault_ov_in,
  input  wire logic        fault_other_in,
  input  wire logic        fault_reset_in,
  output logic      [15:0] freq_cmd_out,
  output logic      [2:0]  multi_out,
  output logic             detect_by_current_out,
  output logic             setting_error_out,
  output logic             fault_restart_out,
  output logic             fault_latched_out
);
  // software-visible settings
  logic        vector_mode;
  logic        torque_detect_source_select;
  logic [3:0]  retry_count_limit;
  logic [15:0] freq_detect_level;
  logic [7:0]  output_function_select [0:2];
  logic [7:0]  offset_mode_select;
  logic [15:0] jump_or_offset_freq [0:2];
  logic [15:0] jump_band_width;
  logic [7:0]  multi_input_select [0:3];
  // bus and internal state
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic [24:0] err_timer;
  logic [3:0]  retry_count;

  // address phase decode; only whole-word accesses are expected
  wire        addr_phase = hsel_in && htrans_in[1] && hready_in && ce_in;
  wire        addr_hit   = haddr_in[31:8] == 24'h000000;
  wire [7:0]  addr_lo    = haddr_in[7:0];
  wire        wr_now     = wr_pend && ce_in;
  wire [3:0]  mode_x     = offset_mode_select[7:dfc_pkg::OFS_X_LSB];
  wire [3:0]  mode_y     = offset_mode_select[3:0];
  wire        mode_jump  = !(mode_x == dfc_pkg::MODE_HZ || mode_x == dfc_pkg::MODE_PCT);
  wire        order_bad  = mode_jump && !(jump_or_offset_freq[0] >= jump_or_offset_freq[1] &&
                                          jump_or_offset_freq[1] >= jump_or_offset_freq[2]);
  wire [3:0]  limit_wr   = (hwdata_in[dfc_pkg::CTRL_LIMIT_LSB +: 4] > dfc_pkg::RETRY_MAX) ?
                           dfc_pkg::RETRY_MAX : hwdata_in[dfc_pkg::CTRL_LIMIT_LSB +: 4];
  // entries above 400 Hz are clamped at the write, so range holds in every mode
  wire [15:0] freq_wr    = (hwdata_in[15:0] > dfc_pkg::FREQ_LIMIT) ? dfc_pkg::FREQ_LIMIT : hwdata_in[15:0];

  assign hreadyout_out = ce_in; // zero wait states while running
  assign hresp_out     = 1'b0;
  assign setting_error_out = err_timer != 25'h0;
  assign detect_by_current_out = !vector_mode || torque_detect_source_select;

  // read mux, sampled in the address phase so the data phase sees a flop
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_hit) begin
      unique case (addr_lo)
        dfc_pkg::ADDR_CTRL: begin
          rd_mux[dfc_pkg::CTRL_VEC_BIT] = vector_mode;
          rd_mux[dfc_pkg::CTRL_SRC_BIT] = torque_detect_source_select;
          rd_mux[dfc_pkg::CTRL_LIMIT_LSB +: 4] = retry_count_limit;
        end
        dfc_pkg::ADDR_FDET:    rd_mux[15:0] = freq_detect_level;
        dfc_pkg::ADDR_OUTSEL:  rd_mux[23:0] = {output_function_select[2], output_function_select[1],
                                                output_function_select[0]};
        dfc_pkg::ADDR_OFSMODE: rd_mux[7:0] = offset_mode_select;
        dfc_pkg::ADDR_FREQ1:   rd_mux[15:0] = jump_or_offset_freq[0];
        dfc_pkg::ADDR_FREQ2:   rd_mux[15:0] = jump_or_offset_freq[1];
        dfc_pkg::ADDR_FREQ3:   rd_mux[15:0] = jump_or_offset_freq[2];
        dfc_pkg::ADDR_JWIDTH:  rd_mux[15:0] = jump_band_width;
        dfc_pkg::ADDR_MISEL:   rd_mux = {multi_input_select[3], multi_input_select[2],
                                         multi_input_select[1], multi_input_select[0]};
        dfc_pkg::ADDR_STATUS: begin
          rd_mux[2:0] = multi_out;
          rd_mux[dfc_pkg::STAT_ERR_BIT]   = setting_error_out;
          rd_mux[dfc_pkg::STAT_LATCH_BIT] = fault_latched_out;
          rd_mux[dfc_pkg::STAT_CUR_BIT]   = detect_by_current_out;
          rd_mux[dfc_pkg::STAT_CNT_LSB +: 4] = retry_count;
        end
        dfc_pkg::ADDR_FCMD:    rd_mux[15:0] = freq_cmd_out;
        default:               rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // bus pipeline: address phase capture, unmapped writes are dropped
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_pend    <= 1'b0;
      wr_addr    <= 8'h00;
      hrdata_out <= 32'h0000_0000;
    end else if (ce_in) begin
      wr_pend <= addr_phase && hwrite_in && addr_hit;
      wr_addr <= addr_lo;
      if (addr_phase && !hwrite_in) begin
        hrdata_out <= rd_mux;
      end
    end
  end

  // settings written in the data phase
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      vector_mode                 <= 1'b0;
      torque_detect_source_select <= 1'b0;
      retry_count_limit           <= 4'h0;
      freq_detect_level           <= dfc_pkg::RST_FREQ;
      offset_mode_select          <= dfc_pkg::RST_OFS_MODE;
      jump_band_width             <= dfc_pkg::RST_FREQ;
      for (int i = 0; i < 3; i++) begin
        output_function_select[i] <= dfc_pkg::RST_CODE;
      end
      for (int i = 0; i < 4; i++) begin
        multi_input_select[i] <= dfc_pkg::RST_CODE;
      end
    end else if (wr_now) begin
      unique case (wr_addr)
        dfc_pkg::ADDR_CTRL: begin
          vector_mode                 <= hwdata_in[dfc_pkg::CTRL_VEC_BIT];
          torque_detect_source_select <= hwdata_in[dfc_pkg::CTRL_SRC_BIT];
          retry_count_limit           <= limit_wr;
        end
        dfc_pkg::ADDR_FDET:    freq_detect_level <= hwdata_in[15:0];
        dfc_pkg::ADDR_OUTSEL: begin
          for (int i = 0; i < 3; i++) begin
            output_function_select[i] <= hwdata_in[8*i +: 8];
          end
        end
        dfc_pkg::ADDR_OFSMODE: offset_mode_select <= hwdata_in[7:0];
        dfc_pkg::ADDR_JWIDTH:  jump_band_width <= hwdata_in[15:0];
        dfc_pkg::ADDR_MISEL: begin
          for (int i = 0; i < 4; i++) begin
            multi_input_select[i] <= hwdata_in[8*i +: 8];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // frequency entries; restore on a misordered set wins over a new write
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      err_timer <= 25'h0;
      for (int i = 0; i < 3; i++) begin
        jump_or_offset_freq[i] <= dfc_pkg::RST_FREQ;
      end
    end else if (ce_in) begin
      if (order_bad) begin
        err_timer <= 25'(ERR_HOLD_CYCLES);
        for (int i = 0; i < 3; i++) begin
          jump_or_offset_freq[i] <= dfc_pkg::RST_FREQ;
        end
      end else begin
        if (err_timer != 25'h0) begin
          err_timer <= err_timer - 25'h1;
        end
        if (wr_pend && wr_addr == dfc_pkg::ADDR_FREQ1) jump_or_offset_freq[0] <= freq_wr;
        if (wr_pend && wr_addr == dfc_pkg::ADDR_FREQ2) jump_or_offset_freq[1] <= freq_wr;
        if (wr_pend && wr_addr == dfc_pkg::ADDR_FREQ3) jump_or_offset_freq[2] <= freq_wr;
      end
    end
  end

  // per entry: band edges, offset select, signed offset term
  logic [2:0]         band_hit;
  logic [15:0]        band_lo [0:2];
  logic [2:0]         ofs_sel;
  logic signed [18:0] ofs_term [0:2];
  logic [7:0]         mi_code [0:2];
  assign mi_code[0] = dfc_pkg::MI_OFS1;
  assign mi_code[1] = dfc_pkg::MI_OFS2;
  assign mi_code[2] = dfc_pkg::MI_OFS3;

  genvar k;
  generate
    for (k = 0; k < 3; k++) begin : g_entry
      wire [15:0] half    = {1'b0, jump_band_width[15:1]};
      wire [15:0] f       = jump_or_offset_freq[k];
      wire [16:0] hi      = {1'b0, f} + {1'b0, half};
      wire [31:0] pct_hz  = (32'(f) * 32'(max_freq_in)) / dfc_pkg::PCT_FULL;
      wire [15:0] mag     = (mode_x == dfc_pkg::MODE_PCT) ? pct_hz[15:0] : f;
      wire        neg     = mode_y[3] | mode_y[k];
      wire [3:0]  in_hits;
      assign band_lo[k]  = (f > half) ? f - half : 16'h0000;
      assign band_hit[k] = (f != 16'h0000) && freq_ref_in >= band_lo[k] &&
                           {1'b0, freq_ref_in} <= hi;
      for (genvar m = 0; m < 4; m++) begin : g_in
        assign in_hits[m] = multi_in[m] && multi_input_select[m] == mi_code[k];
      end
      assign ofs_sel[k]  = |in_hits;
      assign ofs_term[k] = !ofs_sel[k] ? 19'sh00000 :
                           neg ? -$signed({3'b000, mag}) : $signed({3'b000, mag});
    end
  endgenerate

  // steady reference is parked at the lower edge of the first band it sits in
  wire [15:0] jumped = ramping_in  ? freq_ref_in :
                       band_hit[0] ? band_lo[0] :
                       band_hit[1] ? band_lo[1] :
                       band_hit[2] ? band_lo[2] : freq_ref_in;
  // offsets sum then clamp into 0 .. 400 Hz
  wire signed [18:0] ofs_sum = ofs_term[0] + ofs_term[1] + ofs_term[2];
  wire signed [18:0] shifted = $signed({3'b000, freq_ref_in}) + ofs_sum;
  wire [15:0] offset_ref = shifted < 0 ? 16'h0000 :
                           shifted > $signed({3'b000, dfc_pkg::FREQ_LIMIT}) ? dfc_pkg::FREQ_LIMIT :
                           shifted[15:0];
  wire [15:0] next_freq_cmd = mode_jump ? jumped : offset_ref;

  // frequency detection outputs, one per selector
  logic [2:0] next_multi;
  generate
    for (k = 0; k < 3; k++) begin : g_out
      assign next_multi[k] =
        (output_function_select[k] == dfc_pkg::FN_FREQ_GE && out_freq_in >= freq_detect_level) ||
        (output_function_select[k] == dfc_pkg::FN_FREQ_LE && out_freq_in <= freq_detect_level);
    end
  endgenerate

  // registered data outputs
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      freq_cmd_out <= 16'h0000;
      multi_out    <= 3'b000;
    end else if (ce_in) begin
      freq_cmd_out <= next_freq_cmd;
      multi_out    <= next_multi;
    end
  end

  // fault retry sequencer
  dfc_retry #(
    .WINDOW_CYCLES (RETRY_WINDOW_CYCLES)
  ) u_retry (
    .clk_in         (clk_in),
    .rst_in         (rst_in),
    .ce_in          (ce_in),
    .fault_oc_in    (fault_oc_in),
    .fault_ov_in    (fault_ov_in),
    .fault_other_in (fault_other_in),
    .fault_reset_in (fault_reset_in),
    .limit_in       (retry_count_limit),
    .count_out      (retry_count),
    .latched_out    (fault_latched_out),
    .restart_out    (fault_restart_out)
  );

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  AST_SRC_VECTOR: assert property (
    vector_mode && !torque_detect_source_select |-> !detect_by_current_out)
    else $error("vector mode torque source ignored");
  AST_SRC_VF: assert property (
    !vector_mode |-> detect_by_current_out)
    else $error("V/f mode not using current");
  AST_FDET_GE: assert property (
    ce_in && output_function_select[0] == dfc_pkg::FN_FREQ_GE && out_freq_in >= freq_detect_level
    |=> multi_out[0])
    else $error("frequency at or above level not flagged");
  AST_FDET_LE: assert property (
    ce_in && output_function_select[1] == dfc_pkg::FN_FREQ_LE && out_freq_in > freq_detect_level
    |=> !multi_out[1])
    else $error("low detection flagged above level");
  AST_JUMP_ZERO: assert property (
    ce_in && mode_jump && !ramping_in && jump_or_offset_freq[0] == 16'h0000 &&
    jump_or_offset_freq[1] == 16'h0000 && jump_or_offset_freq[2] == 16'h0000
    |=> freq_cmd_out == $past(freq_ref_in))
    else $error("disabled band altered reference");
  AST_ORDER_ERR: assert property (
    ce_in && order_bad |=> setting_error_out && jump_or_offset_freq[0] == 16'h0000 ##1 setting_error_out)
    else $error("misordered entries not restored");
  AST_RAMP_PASS: assert property (
    ce_in && mode_jump && ramping_in |=> freq_cmd_out == $past(freq_ref_in))
    else $error("reference jumped during ramp");
  AST_STEADY_JUMP: assert property (
    ce_in && mode_jump && !ramping_in && band_hit[0] |=> freq_cmd_out == $past(band_lo[0]))
    else $error("steady reference left inside band");
  AST_OFS_NONE: assert property (
    ce_in && !mode_jump && ofs_sel == 3'b000 && freq_ref_in <= dfc_pkg::FREQ_LIMIT
    |=> freq_cmd_out == $past(freq_ref_in))
    else $error("offset applied with no select input");

  // opposite sides of the detection compare, so a flag stuck high or low is caught
  AST_FDET_GE_OFF: assert property (
    ce_in && output_function_select[0] == dfc_pkg::FN_FREQ_GE && out_freq_in < freq_detect_level
    |=> !multi_out[0])
    else $error("high detection flagged below level");
  AST_FDET_LE_ON: assert property (
    ce_in && output_function_select[1] == dfc_pkg::FN_FREQ_LE && out_freq_in <= freq_detect_level
    |=> multi_out[1])
    else $error("frequency at or below level not flagged");

  // clamps at the write keep stored settings inside their ranges
  AST_LIMIT_MAX: assert property (
    retry_count_limit <= dfc_pkg::RETRY_MAX)
    else $error("retry limit above ten");
  AST_ENTRY_RANGE: assert property (
    jump_or_offset_freq[0] <= dfc_pkg::FREQ_LIMIT && jump_or_offset_freq[1] <= dfc_pkg::FREQ_LIMIT &&
    jump_or_offset_freq[2] <= dfc_pkg::FREQ_LIMIT)
    else $error("frequency entry above range");

  // error flag drops on time, and a steady reference outside every band passes
  AST_ERR_EXPIRE: assert property (
    ce_in && !order_bad && err_timer == 25'h1 |=> !setting_error_out)
    else $error("setting error outlived its hold time");
  AST_STEADY_CLEAR: assert property (
    ce_in && mode_jump && !ramping_in && band_hit == 3'b000 |=> freq_cmd_out == $past(freq_ref_in))
    else $error("reference outside bands was moved");
endmodule

/* File: testbench/dfc_top_bench.sv */
// self-checking bench for the drive frequency conditioning block
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module dfc_top_bench;
  logic        clk_in    = 1'b0;
  logic        rst_in    = 1'b1;
  logic        ce_in     = 1'b1;
  logic        hsel_in   = 1'b0;
  logic [31:0] haddr_in  = 32'h0;
  logic [1:0]  htrans_in = 2'h0;
  logic        hwrite_in = 1'b0;
  logic [31:0] hwdata_in = 32'h0;
  logic [15:0] ref_in    = 16'h0;
  logic [15:0] ofreq_in  = 16'h0;
  logic [15:0] maxf_in   = 16'h0;
  logic        ramp_in   = 1'b0;
  logic [3:0]  mi_in     = 4'h0;
  logic [2:0]  flt_in    = 3'h0;
  logic        frst_in   = 1'b0;
  logic [31:0] rd;
  logic        s;
  wire  [31:0] hrdata;
  wire         hready;
  wire         hresp;
  wire  [15:0] fcmd;
  wire  [2:0]  mo;
  wire         dbc;
  wire         serr;
  wire         frestart;
  wire         flatch;
  int          fail_count = 0;
  int          compares   = 0;

  // short counts keep the one-second and ten-minute timers simulable
  dfc_top #(.ERR_HOLD_CYCLES(20), .RETRY_WINDOW_CYCLES(50)) u_dfc_top (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2), .hwdata_in(hwdata_in),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .freq_ref_in(ref_in), .out_freq_in(ofreq_in), .max_freq_in(maxf_in), .ramping_in(ramp_in),
    .multi_in(mi_in), .fault_oc_in(flt_in[0]), .fault_ov_in(flt_in[1]), .fault_other_in(flt_in[2]),
    .fault_reset_in(frst_in), .freq_cmd_out(fcmd), .multi_out(mo), .detect_by_current_out(dbc),
    .setting_error_out(serr), .fault_restart_out(frestart), .fault_latched_out(flatch));

  always #25 clk_in = ~clk_in;

  // one word transfer; waits on hready, no fixed latency assumed
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel_in   <= 1'b1;
    haddr_in  <= {24'h0, a};
    htrans_in <= 2'h2;
    hwrite_in <= wr;
    @(posedge clk_in);
    while (hready !== 1'b1) @(posedge clk_in);
    htrans_in <= 2'h0;
    hsel_in   <= 1'b0;
    hwdata_in <= d;
    @(posedge clk_in);
    while (hready !== 1'b1) @(posedge clk_in);
    rd = hrdata;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // one fault event; reports whether a restart pulse came
  task automatic fault(input int k, output logic seen);
    seen = 1'b0;
    flt_in[k] <= 1'b1;
    repeat (3) begin
      @(posedge clk_in);
      #1 seen = seen | (frestart === 1'b1);
    end
    @(posedge clk_in);
    flt_in[k] <= 1'b0;
    cyc(2);
  endtask

  task automatic t_regs();
    bus(0, dfc_pkg::ADDR_FREQ1, 32'h0);
    `CHK(rd, 32'h0)
    bus(0, 8'h30, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(hresp, 1'b0)
  endtask

  task automatic t_source();
    bus(1, dfc_pkg::ADDR_CTRL, 32'h1);
    cyc(2);
    `CHK(dbc, 1'b0)
    bus(1, dfc_pkg::ADDR_CTRL, 32'h3);
    cyc(2);
    `CHK(dbc, 1'b1)
    bus(1, dfc_pkg::ADDR_CTRL, 32'h0);
    cyc(2);
    `CHK(dbc, 1'b1)
  endtask

  // selector 1 at code 4, selector 2 at code 5, on the level boundary
  task automatic t_fdet();
    bus(1, dfc_pkg::ADDR_OUTSEL, 32'h0000_0504);
    bus(1, dfc_pkg::ADDR_FDET, 32'h0000_03E8);
    ofreq_in <= 16'h03E8;
    cyc(3);
    `CHK(mo, 3'h3)
    ofreq_in <= 16'h03E7;
    cyc(3);
    `CHK(mo, 3'h2)
    ofreq_in <= 16'h03E9;
    cyc(3);
    `CHK(mo, 3'h1)
  endtask

  // bands 3000 and 2000 with width 200, third entry disabled
  task automatic t_jump();
    bus(1, dfc_pkg::ADDR_FREQ1, 32'h0BB8);
    bus(1, dfc_pkg::ADDR_FREQ2, 32'h07D0);
    bus(1, dfc_pkg::ADDR_JWIDTH, 32'h00C8);
    ref_in <= 16'h0BEA;
    cyc(3);
    `CHK(fcmd, 16'h0B54)
    ramp_in <= 1'b1;
    cyc(3);
    `CHK(fcmd, 16'h0BEA)
    ramp_in <= 1'b0;
    ref_in  <= 16'h0032;
    cyc(3);
    `CHK(fcmd, 16'h0032)
    bus(1, dfc_pkg::ADDR_FREQ3, 32'h09C4);
    cyc(2);
    `CHK(serr, 1'b1)
    bus(0, dfc_pkg::ADDR_FREQ1, 32'h0);
    `CHK(rd, 32'h0)
    cyc(25);
    `CHK(serr, 1'b0)
  endtask

  task automatic t_offset();
    bus(1, dfc_pkg::ADDR_MISEL, 32'h0021_1F1E);
    bus(1, dfc_pkg::ADDR_OFSMODE, 32'h11);
    bus(1, dfc_pkg::ADDR_FREQ1, 32'hFFFF);
    bus(0, dfc_pkg::ADDR_FREQ1, 32'h0);
    `CHK(rd, 32'h9C40)
    bus(1, dfc_pkg::ADDR_FREQ1, 32'h01F4);
    bus(1, dfc_pkg::ADDR_FREQ2, 32'h012C);
    bus(1, dfc_pkg::ADDR_FREQ3, 32'h0064);
    ref_in <= 16'h07D0;
    mi_in  <= 4'h7;
    cyc(3);
    `CHK(fcmd, 16'h076C)
    mi_in <= 4'h2;
    cyc(3);
    `CHK(fcmd, 16'h08FC)
    bus(1, dfc_pkg::ADDR_OFSMODE, 32'h20);
    bus(1, dfc_pkg::ADDR_FREQ1, 32'h03E8);
    maxf_in <= 16'h2710;
    mi_in   <= 4'h1;
    cyc(3);
    `CHK(fcmd, 16'h0BB8)
    mi_in <= 4'h0;
  endtask

  // clock enable low stalls the bus and freezes the conditioned reference
  task automatic t_freeze();
    ce_in  <= 1'b0;
    ref_in <= 16'h0FA0;
    cyc(3);
    `CHK(hready, 1'b0)
    `CHK(fcmd, 16'h0BB8)
    ce_in <= 1'b1;
    cyc(2);
    `CHK(fcmd, 16'h0FA0)
  endtask

  task automatic t_retry();
    bus(1, dfc_pkg::ADDR_CTRL, 32'h0F00);
    bus(0, dfc_pkg::ADDR_CTRL, 32'h0);
    `CHK(rd[11:8], 4'hA)
    bus(1, dfc_pkg::ADDR_CTRL, 32'h0200);
    fault(0, s);
    `CHK(s, 1'b1)
    fault(1, s);
    `CHK(s, 1'b1)
    fault(0, s);
    `CHK(s, 1'b0)
    `CHK(flatch, 1'b1)
    frst_in <= 1'b1;
    cyc(2);
    frst_in <= 1'b0;
    bus(0, dfc_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd[11:8], 4'h0)
    `CHK(flatch, 1'b0)
    fault(2, s);
    `CHK(s, 1'b0)
    `CHK(flatch, 1'b1)
    frst_in <= 1'b1;
    cyc(2);
    frst_in <= 1'b0;
    fault(0, s);
    bus(0, dfc_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd[11:8], 4'h1)
    cyc(60);
    bus(0, dfc_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd[11:8], 4'h0)
  endtask

  task automatic conclude();
    if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    cyc(3);
    rst_in <= 1'b0;
    cyc(1);
    t_regs();
    t_source();
    t_fdet();
    t_jump();
    t_offset();
    t_freeze();
    t_retry();
    conclude();
  end

  // the run needs well under a thousand cycles
  initial begin
    cyc(5000);
    fail_count++;
    conclude();
  end
endmodule
